// >>> pkg/chain_cfg.svh
// Notes on behaviour
// R1 - host shares one start and clock line
// R2 - first input low, outputs feed next inputs
// R3 - output low while input and start low
// R4 - start rise with input low begins conversion
// R5 - input tied to start also selects chain
// R6 - host holds start high through readout
// R7 - conversion completes regardless of serial clock
// R8 - serial clock low when start rises
// R9 - result loaded, msb shown at conversion end
// R10 - acquisition and power down after conversion
// R11 - falling clock edge shifts input, drives next
// R12 - host receives last device first, msb first
// R13 - host issues sixteen times n falling edges
// R14 - host may capture on either edge
// R15 - host waits maximum conversion time first
`ifndef CHAIN_CFG_SVH
`define CHAIN_CFG_SVH
`define RESULT_BITS 16
`define CONV_MAX_NS 8000
`define CLK_PERIOD_NS 4
`define CONV_CYCLES ((`CONV_MAX_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CONV_CNT_W 12
`define SCLK_HALF_CYCLES 6
`define BIT_CNT_W 12
`endif

// >>> pkg/chain_pkg.sv
`default_nettype none
`include "chain_cfg.svh"
package chain_pkg;
  typedef logic [`RESULT_BITS-1:0] result_t;
  typedef enum logic [1:0] {DEV_IDLE, DEV_CONVERT, DEV_ACQUIRE} dev_state_t;
  typedef enum logic [1:0] {HOST_IDLE, HOST_WAIT, HOST_SHIFT, HOST_DONE} host_state_t;
endpackage
`default_nettype wire

// >>> pkg/chain_if.sv
`timescale 1ns/1ps
`default_nettype none
interface chain_if;
  logic convert_start;
  logic serial_clk;
  logic host_data_in;
  modport device (input convert_start, input serial_clk, output host_data_in);
  modport host (output convert_start, output serial_clk, input host_data_in);
endinterface
`default_nettype wire

// >>> src/adc_chain_device.sv
`timescale 1ns/1ps
`default_nettype none
`include "chain_cfg.svh"
module adc_chain_device (
  input  wire logic           clk,
  input  wire logic           sys_rst,
  chain_if.device             link,
  input  wire logic           chain_serial_in,
  input  wire chain_pkg::result_t sample_value,
  output var  logic           converting,
  output var  logic           powered_down
);
  import chain_pkg::*;
  logic [2:0] start_sync_q;
  logic [2:0] sclk_sync_q;
  logic [2:0] din_sync_q;
  logic [`CONV_CNT_W-1:0] conv_cnt_q;
  result_t sample_q;
  result_t shift_q;
  logic dout_q;
  dev_state_t state_q;
  // synchronisers; bit 0 read only by bit 1
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      start_sync_q <= 3'h0;
      sclk_sync_q  <= 3'h0;
      din_sync_q   <= 3'h0;
    end else begin
      start_sync_q <= {start_sync_q[1:0], link.convert_start};
      sclk_sync_q  <= {sclk_sync_q[1:0], link.serial_clk};
      din_sync_q   <= {din_sync_q[1:0], chain_serial_in};
    end
  end
  wire start_lvl  = start_sync_q[1];
  wire start_rise = start_sync_q[1] & ~start_sync_q[2];
  wire sclk_fall  = ~sclk_sync_q[1] & sclk_sync_q[2];
  wire din_lvl    = din_sync_q[1];
  wire din_before = din_sync_q[2];
  // input level just before the rise; a tied input is still low there
  wire chain_sel  = start_rise & ~din_before; // R4 R5
  wire conv_end   = (state_q == DEV_CONVERT) && (conv_cnt_q == `CONV_CNT_W'(`CONV_CYCLES - 1));
  // conversion runs on its own count, serial clock ignored meanwhile
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q    <= DEV_IDLE;
      conv_cnt_q <= `CONV_CNT_W'h000;
      sample_q   <= `RESULT_BITS'h0000;
      shift_q    <= `RESULT_BITS'h0000;
      dout_q     <= 1'b0;
    end else begin
      case (state_q)
        DEV_IDLE, DEV_ACQUIRE: begin
          if (chain_sel) begin
            state_q    <= DEV_CONVERT; // R4
            conv_cnt_q <= `CONV_CNT_W'h000;
            sample_q   <= sample_value;
          end else if (state_q == DEV_ACQUIRE && sclk_fall) begin
            shift_q <= {shift_q[`RESULT_BITS-2:0], din_lvl}; // R11
            dout_q  <= shift_q[`RESULT_BITS-2];
          end else if (!start_lvl && !din_lvl) begin
            dout_q <= 1'b0; // R3
          end
        end
        DEV_CONVERT: begin
          conv_cnt_q <= conv_cnt_q + `CONV_CNT_W'h001; // R7
          if (conv_end) begin
            state_q <= DEV_ACQUIRE; // R10
            shift_q <= sample_q; // R9
            dout_q  <= sample_q[`RESULT_BITS-1];
          end
        end
        default: state_q <= DEV_IDLE;
      endcase
    end
  end
  // status flags registered so outputs come straight from flops
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      converting   <= 1'b0;
      powered_down <= 1'b1;
    end else begin
      converting   <= (state_q == DEV_CONVERT);
      powered_down <= (state_q != DEV_CONVERT); // R10
    end
  end
  assign link.host_data_in = dout_q;
endmodule
`default_nettype wire

// >>> src/adc_chain_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "chain_cfg.svh"
module adc_chain_host (
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  chain_if.host                      link,
  input  wire logic                  start_req,
  input  wire logic [7:0]            device_count,
  output var  logic                  busy,
  output var  logic                  word_valid,
  output var  chain_pkg::result_t    word_data
);
  import chain_pkg::*;
  host_state_t state_q;
  logic [`CONV_CNT_W-1:0] wait_q;
  logic [3:0] half_q;
  logic [`BIT_CNT_W-1:0] bits_q;
  logic [3:0] word_bits_q;
  logic [1:0] sdi_sync_q;
  logic start_q;
  logic sclk_q;
  result_t acc_q;
  wire [`BIT_CNT_W-1:0] total_bits = `BIT_CNT_W'(device_count) * `BIT_CNT_W'(`RESULT_BITS); // R13
  wire half_done = (half_q == 4'(`SCLK_HALF_CYCLES - 1));
  // data input is sampled through two flops before use
  always_ff @(posedge clk) begin
    if (sys_rst) sdi_sync_q <= 2'h0;
    else sdi_sync_q <= {sdi_sync_q[0], link.host_data_in};
  end
  // sequencer: start high, wait conversion, then clock out 16*n bits
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= HOST_IDLE;
      start_q <= 1'b0;
      sclk_q  <= 1'b0;
      wait_q  <= `CONV_CNT_W'h000;
      half_q  <= 4'h0;
      bits_q  <= `BIT_CNT_W'h000;
      word_bits_q <= 4'h0;
      acc_q <= `RESULT_BITS'h0000;
      word_valid <= 1'b0;
      word_data <= `RESULT_BITS'h0000;
    end else begin
      word_valid <= 1'b0;
      case (state_q)
        HOST_IDLE: begin
          sclk_q <= 1'b0; // R8
          if (start_req && device_count != 8'h00) begin
            start_q <= 1'b1; // R1
            wait_q  <= `CONV_CNT_W'h000;
            state_q <= HOST_WAIT;
          end
        end
        HOST_WAIT: begin
          // margin of a few cycles covers device-side sync delay
          wait_q <= wait_q + `CONV_CNT_W'h001;
          if (wait_q == `CONV_CNT_W'(`CONV_CYCLES + 8)) begin
            state_q <= HOST_SHIFT; // R15
            half_q <= 4'h0;
            bits_q <= `BIT_CNT_W'h000;
            word_bits_q <= 4'h0;
          end
        end
        HOST_SHIFT: begin
          half_q <= half_done ? 4'h0 : half_q + 4'h1;
          if (half_done) begin
            sclk_q <= ~sclk_q;
            if (!sclk_q) begin
              // capture on rising edge, bit stable since last fall
              acc_q <= {acc_q[`RESULT_BITS-2:0], sdi_sync_q[1]}; // R12 R14
              word_bits_q <= word_bits_q + 4'h1;
              if (word_bits_q == 4'hF) begin
                word_valid <= 1'b1;
                word_data  <= {acc_q[`RESULT_BITS-2:0], sdi_sync_q[1]};
              end
            end else begin
              bits_q <= bits_q + `BIT_CNT_W'h001;
              if (bits_q == total_bits - `BIT_CNT_W'h001) state_q <= HOST_DONE;
            end
          end
        end
        HOST_DONE: begin
          start_q <= 1'b0; // R6
          state_q <= HOST_IDLE;
        end
        default: state_q <= HOST_IDLE;
      endcase
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) busy <= 1'b0;
    else busy <= (state_q != HOST_IDLE) || start_req;
  end
  assign link.convert_start = start_q;
  assign link.serial_clk = sclk_q;
endmodule
`default_nettype wire

// >>> testbench/chain_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "chain_cfg.svh"
module chain_asserts (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic convert_start,
  input wire logic serial_clk,
  input wire logic host_data_in
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // cycles since the start line rose, saturating
  logic [11:0] since_start_q;
  always_ff @(posedge clk) begin
    if (sys_rst || !convert_start) since_start_q <= 12'h000;
    else if (since_start_q != 12'hFFF) since_start_q <= since_start_q + 12'h001;
  end
  AST_CONV_WAIT: assert property ($fell(serial_clk) |-> since_start_q >= 12'(`CONV_CYCLES))
    else $error("clock before conversion end");
  // one high phase of the link clock, six cycles
  sequence hi_phase;
    serial_clk[*6] ##1 !serial_clk;
  endsequence
  AST_SCLK_LOW_AT_START: assert property ($rose(convert_start) |-> !serial_clk)
    else $error("clock high at start");
  AST_NO_EARLY_CLK: assert property ($rose(convert_start) |-> !serial_clk[*8])
    else $error("clock too soon");
  AST_CLK_IN_FRAME: assert property (serial_clk |-> convert_start)
    else $error("clock outside frame");
  AST_START_HELD: assert property ($rose(convert_start) |-> convert_start[*8])
    else $error("start dropped");
  AST_END_CLK_LOW: assert property ($fell(convert_start) |-> !serial_clk)
    else $error("frame ends mid clock");
  AST_HALF_PERIOD: assert property ($rose(serial_clk) |-> hi_phase)
    else $error("clock phase length");
  // data may move only after a falling edge
  AST_DATA_STEADY: assert property ($rose(serial_clk) |-> $stable(host_data_in)[*6])
    else $error("data moved while clock high");
  AST_IDLE_LOW: assert property ((!convert_start)[*8] |-> !host_data_in)
    else $error("output high while idle");
endmodule
`default_nettype wire

// >>> testbench/adc_daisy_chain_readout_tb.sv
`timescale 1ns/1ps
`default_nettype none
module adc_daisy_chain_readout_tb;
  import chain_pkg::*;
  logic    clk = 0, sys_rst = 1, start_req = 0, busy, word_valid, conv, pdn, conv_tied;
  logic [7:0] device_count = 8'h01;
  result_t s0 = '0, s1 = '0, word_data;
  int      num_errors = 0, samples_checked = 0;
  result_t exp_q[$];
  chain_if hif ();
  chain_if fif ();
  chain_if tif ();
  // extra device with its input tied to start, off the chain
  assign tif.convert_start = hif.convert_start;
  assign tif.serial_clk = hif.serial_clk;
  adc_chain_device adc_chain_device_i2 (.clk(clk), .sys_rst(sys_rst), .link(tif),
    .chain_serial_in(tif.convert_start), .sample_value(s0), .converting(conv_tied),
    .powered_down());
  // all three devices share the host's start and clock lines
  assign fif.convert_start = hif.convert_start;
  assign fif.serial_clk = hif.serial_clk;
  adc_chain_host adc_chain_host_i (.clk(clk), .sys_rst(sys_rst), .link(hif),
    .start_req(start_req), .device_count(device_count), .busy(busy),
    .word_valid(word_valid), .word_data(word_data));
  adc_chain_device adc_chain_device_i0 (.clk(clk), .sys_rst(sys_rst), .link(fif),
    .chain_serial_in(1'h0), .sample_value(s0), .converting(), .powered_down());
  adc_chain_device adc_chain_device_i (.clk(clk), .sys_rst(sys_rst), .link(hif),
    .chain_serial_in(fif.host_data_in), .sample_value(s1), .converting(conv),
    .powered_down(pdn));
  chain_asserts chain_asserts_i (.clk(clk), .sys_rst(sys_rst),
    .convert_start(hif.convert_start), .serial_clk(hif.serial_clk),
    .host_data_in(hif.host_data_in));
  initial forever #2 clk = ~clk;
  task automatic end_sim();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // bounded wait on busy; a hang ends the run
  task automatic wait_busy(input logic lvl);
    int n;
    n = 0;
    while (busy !== lvl && n < 5000) begin
      @(posedge clk);
      n++;
    end
    if (busy !== lvl) begin
      num_errors++;
      $display("BAD %0t timeout", $time);
      end_sim();
    end
  endtask
  // every reported word against the oldest note
  always @(posedge clk) begin
    if (word_valid === 1'h1) begin
      samples_checked++;
      if (exp_q.size() == 0 || word_data !== exp_q[0]) begin
        num_errors++;
        $display("BAD %0t word %h", $time, word_data);
      end
      if (exp_q.size() != 0) void'(exp_q.pop_front());
    end
  end
  // frames of one, two and three words; the third is past the chain's head
  initial begin
    void'($urandom(61));
    repeat (2) @(posedge clk);
    sys_rst <= 1'h0;
    for (int n = 1; n <= 3; n++) begin
      @(posedge clk);
      s0 <= result_t'($urandom);
      s1 <= result_t'($urandom);
      device_count <= 8'(n);
      @(posedge clk);
      exp_q.push_back(s1);
      if (n > 1) exp_q.push_back(s0);
      if (n > 2) exp_q.push_back(16'h0000);
      start_req <= 1'h1;
      @(posedge clk);
      start_req <= 1'h0;
      wait_busy(1'h1);
      repeat (20) @(posedge clk);
      samples_checked++;
      if (conv !== 1'h1 || pdn !== 1'h0 || conv_tied !== 1'h1) begin
        num_errors++;
        $display("BAD %0t conversion not started", $time);
      end
      wait_busy(1'h0);
      repeat (20) @(posedge clk);
      samples_checked++;
      if (pdn !== 1'h1 || conv !== 1'h0 || conv_tied !== 1'h0 || exp_q.size() != 0) begin
        num_errors++;
        $display("BAD %0t frame end state", $time);
      end
      $display("test %0d done", n);
    end
    end_sim();
  end
endmodule
`default_nettype wire
